// *** dhs_port.sv ***
// Dual host serial port: single-wire link and I2C slave with protocol switch
`timescale 1ns/10ps

// What this block does
// - Single-wire bytes and words shift LSB first
// - Command bits 0-6 code, bit 7 direction
// - Accept or return 8 or 16 data bits
// - Bit frame starts with start-low pulse
// - Data valid from setup to valid time
// - Release by stop setup, high till cycle end
// - Line low for break time means break
// - Hold mode at I2C but answer neither host until the stored flag is valid, then start in the stored protocol
// - I2C answers only address 1010101
// - Quick read returns data at pointer
// - Pointer advances on each acknowledged byte
// - Consecutive write bytes go to consecutive locations
// - Nack data written to read-only location
// - Nack command byte above 0x7F
// - Nack every surplus incremental write byte
// - Release lines after bus-low timeout
// - Lines still held low means sleep
// - 0x7C40 to control selects single-wire
// - Store flag, silent while switching, new protocol
// - 0x29E7 to control returns to I2C
module dhs_port #(
  parameter int BUS_LOW_CYC = dhs_pkg::BUS_LOW_CYC_DEF,
  parameter int SWITCH_CYC  = dhs_pkg::SWITCH_CYC_DEF
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_sw_line,
  output logic            o_sw_oe,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_ro,
  input  wire logic       i_reg_wide,
  output logic [6:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  input  wire logic       i_nv_valid,
  input  wire logic       i_nv_mode,
  output logic            o_nv_wr,
  output logic            o_nv_mode,
  output logic            o_mode_sw,
  output logic            o_busy,
  output logic            o_sleep
);

  typedef struct packed {
    logic              ready;
    logic              mode_sw;
    logic [23:0]       busy_cnt;
    logic              busy;
    logic              nv_wr;
    logic              nv_mode;
    logic [6:0]        addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic [7:0]        ctl_lo;
    logic              ctl_seen;
    dhs_pkg::dhs_sw_e  sw_st;
    logic              sw_prev;
    logic [15:0]       sw_since;
    logic [15:0]       sw_low;
    logic [15:0]       sw_tcnt;
    logic [15:0]       sw_sh;
    logic [4:0]        sw_bits;
    logic [4:0]        sw_len;
    logic              sw_pend;
    logic [7:0]        sw_hi;
    logic              sw_oe;
    dhs_pkg::dhs_i2c_e i_st;
    dhs_pkg::dhs_i2c_e i_nx;
    logic              scl_p;
    logic              sda_p;
    logic [7:0]        i_sh;
    logic [3:0]        i_bits;
    logic [6:0]        i_ptr;
    logic [1:0]        i_nwr;
    logic [23:0]       i_low;
    logic              i_rel;
    logic              sda_oe;
    logic              sleep;
  } dhs_state_s;

  dhs_state_s r_reg;
  dhs_state_s r_next;

  logic       do_wr;
  logic [6:0] wa;
  logic [7:0] wd;
  logic       rise;
  logic       fall;
  logic       i_start;
  logic       i_stop;
  logic       sw_fall;
  logic [7:0] sw_byte;
  logic       sw_smp;

  assign rise    = !r_reg.scl_p && i_scl;
  assign fall    = r_reg.scl_p && !i_scl;
  assign i_start = i_scl && r_reg.scl_p && r_reg.sda_p && !i_sda;
  assign i_stop  = i_scl && r_reg.scl_p && !r_reg.sda_p && i_sda;
  assign sw_fall = r_reg.sw_prev && !i_sw_line;
  assign sw_byte = {i_sw_line, r_reg.sw_sh[15:9]};
  assign sw_smp  = r_reg.sw_since == 16'(dhs_pkg::SW_SAMPLE_CYC);

  always_comb
  begin
    r_next = r_reg;
    do_wr  = 1'b0;
    wa     = r_reg.i_ptr;
    wd     = r_reg.i_sh;
    r_next.wr    = 1'b0;
    r_next.rd    = 1'b0;
    r_next.nv_wr = 1'b0;
    r_next.scl_p   = i_scl;
    r_next.sda_p   = i_sda;
    r_next.sw_prev = i_sw_line;

    // ==========================================================
    // Start-up and protocol switch
    if (!r_reg.ready)
    begin
      if (i_nv_valid)
      begin
        r_next.ready   = 1'b1;
        r_next.mode_sw = i_nv_mode;
      end
    end else if (r_reg.busy_cnt != 24'h000000)
    begin
      // Stays deaf for the whole switch countdown, then changes protocol
      r_next.busy_cnt = r_reg.busy_cnt - 24'h000001;
      if (r_reg.busy_cnt == 24'h000001)
        r_next.mode_sw = r_reg.nv_mode;
    end else if (r_reg.mode_sw)
    begin
      // ==========================================================
      // Single-wire link
      r_next.sw_since = sw_fall ? 16'h0000 :
        (r_reg.sw_since == 16'hffff ? 16'hffff : r_reg.sw_since + 16'h0001);
      r_next.sw_low = i_sw_line ? 16'h0000 :
        (r_reg.sw_low == 16'hffff ? 16'hffff : r_reg.sw_low + 16'h0001);
      if (r_reg.sw_pend)
      begin
        do_wr          = 1'b1;
        wa             = 7'(r_reg.addr + 7'h01);
        wd             = r_reg.sw_hi;
        r_next.sw_pend = 1'b0;
      end
      if (!r_reg.sw_oe && !i_sw_line &&
          r_reg.sw_low == 16'(dhs_pkg::SW_BREAK_CYC - 1))
      begin
        r_next.sw_st   = dhs_pkg::SW_CMD;
        r_next.sw_bits = 5'h00;
      end else
      begin
        unique case (r_reg.sw_st)
          dhs_pkg::SW_BRK:
            r_next.sw_bits = 5'h00;
          dhs_pkg::SW_CMD:
            if (sw_smp)
            begin
              r_next.sw_sh   = {i_sw_line, r_reg.sw_sh[15:1]};
              r_next.sw_bits = r_reg.sw_bits + 5'h01;
              if (r_reg.sw_bits == 5'h07)
              begin
                r_next.addr    = sw_byte[6:0];
                r_next.sw_bits = 5'h00;
                r_next.sw_tcnt = 16'h0000;
                r_next.sw_st   = sw_byte[dhs_pkg::SW_WRITE_BIT] ?
                                 dhs_pkg::SW_DATA : dhs_pkg::SW_TURN;
              end
            end
          dhs_pkg::SW_DATA:
            if (sw_smp)
            begin
              r_next.sw_sh   = {i_sw_line, r_reg.sw_sh[15:1]};
              r_next.sw_bits = r_reg.sw_bits + 5'h01;
              if (r_reg.sw_bits == 5'h00)
                r_next.sw_len = i_reg_wide ? 5'h10 : 5'h08;
              if (r_reg.sw_bits + 5'h01 == (r_reg.sw_bits == 5'h00 ?
                  (i_reg_wide ? 5'h10 : 5'h08) : r_reg.sw_len))
              begin
                do_wr        = 1'b1;
                wa           = r_reg.addr;
                wd           = (r_reg.sw_len == 5'h10) ? r_reg.sw_sh[8:1] : sw_byte;
                r_next.sw_hi = sw_byte;
                r_next.sw_pend = r_reg.sw_len == 5'h10;
                r_next.sw_st   = dhs_pkg::SW_CMD;
                r_next.sw_bits = 5'h00;
              end
            end
          dhs_pkg::SW_TURN:
          begin
            // Fetch low then high byte while the host is quiet
            r_next.sw_tcnt = r_reg.sw_tcnt + 16'h0001;
            if (r_reg.sw_tcnt == 16'h0000)
              r_next.rd = 1'b1;
            if (r_reg.sw_tcnt == 16'h0001)
            begin
              r_next.sw_sh[7:0] = i_reg_rdata;
              r_next.sw_len     = i_reg_wide ? 5'h10 : 5'h08;
              r_next.addr       = 7'(r_reg.addr + 7'h01);
              r_next.rd         = i_reg_wide;
            end
            if (r_reg.sw_tcnt == 16'h0002)
            begin
              r_next.sw_sh[15:8] = i_reg_rdata;
              r_next.addr        = 7'(r_reg.addr - 7'h01);
            end
            // Pulling low before the host's frame ends would corrupt its last bit
            if (r_reg.sw_tcnt == 16'(dhs_pkg::SW_TX_WAIT_CYC))
            begin
              r_next.sw_tcnt = 16'h0000;
              r_next.sw_st   = dhs_pkg::SW_TX;
            end
          end
          dhs_pkg::SW_TX:
          begin
            r_next.sw_tcnt = r_reg.sw_tcnt + 16'h0001;
            if (r_reg.sw_tcnt < 16'(dhs_pkg::SW_START_CYC))
              r_next.sw_oe = 1'b1;
            else if (r_reg.sw_tcnt < 16'(dhs_pkg::SW_VALID_CYC))
              r_next.sw_oe = !r_reg.sw_sh[0];
            else
              r_next.sw_oe = 1'b0;
            if (r_reg.sw_tcnt == 16'(dhs_pkg::SW_CYCLE_CYC - 1))
            begin
              r_next.sw_tcnt = 16'h0000;
              r_next.sw_sh   = {1'b0, r_reg.sw_sh[15:1]};
              r_next.sw_bits = r_reg.sw_bits + 5'h01;
              if (r_reg.sw_bits + 5'h01 == r_reg.sw_len)
              begin
                r_next.sw_st   = dhs_pkg::SW_CMD;
                r_next.sw_bits = 5'h00;
              end
            end
          end
        endcase
      end
    end else
    begin
      // ==========================================================
      // I2C slave
      // A toggling clock is activity; only a line stuck low runs the timer
      r_next.i_low = ((i_scl && i_sda) || rise || fall) ? 24'h000000 :
        (r_reg.i_low == 24'hffffff ? r_reg.i_low : r_reg.i_low + 24'h000001);
      r_next.i_rel = 1'b0;
      if (r_reg.i_rel && (!i_scl || !i_sda))
        r_next.sleep = 1'b1;
      if (r_reg.sleep)
      begin
        if (i_scl && i_sda)
          r_next.sleep = 1'b0;
      end else if (r_reg.i_low == 24'(BUS_LOW_CYC - 1))
      begin
        // Our clock is never stretched, so only data needs letting go
        r_next.sda_oe = 1'b0;
        r_next.i_st   = dhs_pkg::I_IDLE;
        r_next.i_rel  = 1'b1;
      end else if (i_start)
      begin
        r_next.i_st   = dhs_pkg::I_ADDR;
        r_next.i_bits = 4'h0;
        r_next.sda_oe = 1'b0;
      end else if (i_stop)
      begin
        r_next.i_st   = dhs_pkg::I_IDLE;
        r_next.sda_oe = 1'b0;
      end else if (rise)
      begin
        unique case (r_reg.i_st)
          dhs_pkg::I_ADDR, dhs_pkg::I_CMD, dhs_pkg::I_WR:
          begin
            r_next.i_sh   = {r_reg.i_sh[6:0], i_sda};
            r_next.i_bits = r_reg.i_bits + 4'h1;
          end
          dhs_pkg::I_RD:
            r_next.i_bits = r_reg.i_bits + 4'h1;
          dhs_pkg::I_MACK:
            if (!i_sda)
            begin
              r_next.i_ptr = 7'(r_reg.i_ptr + 7'h01);
              r_next.i_st  = dhs_pkg::I_ACK;
              r_next.i_nx  = dhs_pkg::I_RD;
            end else
              r_next.i_st = dhs_pkg::I_SKIP;
          default:
            r_next.i_st = r_reg.i_st;
        endcase
      end else if (fall)
      begin
        unique case (r_reg.i_st)
          dhs_pkg::I_ADDR:
            if (r_reg.i_bits == 4'h8)
            begin
              r_next.i_bits = 4'h0;
              if (r_reg.i_sh[7:1] == dhs_pkg::I2C_ADDR)
              begin
                r_next.sda_oe = 1'b1;
                r_next.i_st   = dhs_pkg::I_ACK;
                r_next.i_nx   = r_reg.i_sh[0] ? dhs_pkg::I_RD : dhs_pkg::I_CMD;
              end else
                r_next.i_st = dhs_pkg::I_SKIP;
            end
          dhs_pkg::I_CMD:
            if (r_reg.i_bits == 4'h8)
            begin
              r_next.i_bits = 4'h0;
              if (r_reg.i_sh[dhs_pkg::CMD_HI_BIT])
                r_next.i_st = dhs_pkg::I_SKIP;
              else
              begin
                r_next.i_ptr  = r_reg.i_sh[6:0];
                r_next.i_nwr  = 2'h0;
                r_next.sda_oe = 1'b1;
                r_next.i_st   = dhs_pkg::I_ACK;
                r_next.i_nx   = dhs_pkg::I_WR;
              end
            end
          dhs_pkg::I_WR:
            if (r_reg.i_bits == 4'h8)
            begin
              r_next.i_bits = 4'h0;
              if (i_reg_ro)
                r_next.i_st = dhs_pkg::I_SKIP;
              else if (r_reg.i_nwr == dhs_pkg::WR_MAX)
                r_next.i_st = dhs_pkg::I_SKIP;
              else
              begin
                do_wr         = 1'b1;
                r_next.i_ptr  = 7'(r_reg.i_ptr + 7'h01);
                r_next.i_nwr  = r_reg.i_nwr + 2'h1;
                r_next.sda_oe = 1'b1;
                r_next.i_st   = dhs_pkg::I_ACK;
                r_next.i_nx   = dhs_pkg::I_WR;
              end
            end
          dhs_pkg::I_ACK:
          begin
            r_next.sda_oe = 1'b0;
            r_next.i_st   = r_reg.i_nx;
            r_next.i_bits = 4'h0;
            if (r_reg.i_nx == dhs_pkg::I_RD)
            begin
              r_next.i_sh   = i_reg_rdata;
              r_next.rd     = 1'b1;
              r_next.sda_oe = !i_reg_rdata[7];
            end
          end
          dhs_pkg::I_RD:
            if (r_reg.i_bits == 4'h8)
            begin
              r_next.sda_oe = 1'b0;
              r_next.i_st   = dhs_pkg::I_MACK;
            end else
            begin
              r_next.i_sh   = {r_reg.i_sh[6:0], 1'b0};
              r_next.sda_oe = !r_reg.i_sh[6];
            end
          default:
            r_next.i_st = r_reg.i_st;
        endcase
      end
    end

    // ==========================================================
    // Register strobes and control-code watcher
    if (!r_reg.mode_sw)
      r_next.addr = r_next.i_ptr;
    r_next.wr = do_wr;
    if (do_wr)
    begin
      r_next.addr  = wa;
      r_next.wdata = wd;
      if (wa == dhs_pkg::CTL_LOC)
      begin
        r_next.ctl_lo   = wd;
        r_next.ctl_seen = 1'b1;
      end else
        r_next.ctl_seen = 1'b0;
      if (wa == 7'(dhs_pkg::CTL_LOC + 7'h01) && r_reg.ctl_seen &&
          (({wd, r_reg.ctl_lo} == dhs_pkg::CODE_TO_SW && !r_reg.mode_sw) ||
           ({wd, r_reg.ctl_lo} == dhs_pkg::CODE_TO_I2C && r_reg.mode_sw)))
      begin
        r_next.nv_wr    = 1'b1;
        r_next.nv_mode  = !r_reg.mode_sw;
        r_next.busy_cnt = 24'(SWITCH_CYC);
        r_next.sda_oe   = 1'b0;
        r_next.sw_oe    = 1'b0;
        r_next.i_st     = dhs_pkg::I_IDLE;
        r_next.sw_st    = dhs_pkg::SW_BRK;
        r_next.sw_pend  = 1'b0;
      end
    end
    r_next.busy = r_next.busy_cnt != 24'h000000;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      r_reg          <= '0;
      r_reg.mode_sw  <= dhs_pkg::MODE_I2C_RST;
      r_reg.sw_since <= 16'hffff;
      r_reg.sw_prev  <= 1'b1;
      r_reg.scl_p    <= 1'b1;
      r_reg.sda_p    <= 1'b1;
    end else if (i_clk_en)
      r_reg <= r_next;
  end

  assign o_sw_oe     = r_reg.sw_oe;
  assign o_sda_oe    = r_reg.sda_oe;
  assign o_reg_addr  = r_reg.addr;
  assign o_reg_wdata = r_reg.wdata;
  assign o_reg_wr    = r_reg.wr;
  assign o_reg_rd    = r_reg.rd;
  assign o_nv_wr     = r_reg.nv_wr;
  assign o_nv_mode   = r_reg.nv_mode;
  assign o_mode_sw   = r_reg.mode_sw;
  assign o_busy      = r_reg.busy;
  assign o_sleep     = r_reg.sleep;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset || !i_clk_en);

  a_cmd_high_nack: assert property (
    r_reg.ready && !o_busy && !o_mode_sw && !o_sleep && fall && !i_start && !i_stop &&
    r_reg.i_st == dhs_pkg::I_CMD && r_reg.i_bits == 4'h8 && r_reg.i_sh[7] &&
    r_reg.i_low != 24'(BUS_LOW_CYC - 1)
    |=> !o_sda_oe && r_reg.i_st == dhs_pkg::I_SKIP)
    else $error("command above 0x7f was acknowledged");
  a_ro_nack: assert property (
    r_reg.i_st == dhs_pkg::I_WR && i_reg_ro && fall && r_reg.i_bits == 4'h8 &&
    !o_busy && !o_mode_sw && !o_sleep |=> !o_reg_wr)
    else $error("read-only write accepted");
  a_ptr_advance: assert property (
    o_reg_wr && !o_mode_sw |-> r_reg.i_ptr == 7'(o_reg_addr + 7'h01))
    else $error("pointer did not advance after write");
  a_surplus_nack: assert property (
    o_reg_wr && !o_mode_sw |-> r_reg.i_nwr != 2'h0 && r_reg.i_nwr <= dhs_pkg::WR_MAX)
    else $error("surplus write byte accepted");
  a_addr_match: assert property (
    $rose(o_sda_oe) && $past(r_reg.i_st) == dhs_pkg::I_ADDR
    |-> $past(r_reg.i_sh[7:1]) == dhs_pkg::I2C_ADDR)
    else $error("acknowledged a foreign address");
  a_switch_quiet: assert property (
    $rose(o_busy) |-> !o_sda_oe && !o_sw_oe ##1 (!o_reg_wr && !o_sda_oe) [*8])
    else $error("port active while switching");
  a_switch_mode: assert property (
    o_nv_wr |-> o_nv_mode != o_mode_sw && o_busy)
    else $error("switch stored wrong protocol");
  a_bus_release: assert property (
    r_reg.ready && !o_busy && !o_mode_sw && !o_sleep &&
    r_reg.i_low == 24'(BUS_LOW_CYC - 1) |=> !o_sda_oe ##1 !o_sda_oe)
    else $error("lines not released after timeout");
  a_sleep_entry: assert property (
    r_reg.i_rel && !o_busy && !o_mode_sw && !i_scl |=> o_sleep)
    else $error("no sleep with bus held low");
  a_break_seen: assert property (
    r_reg.ready && !o_busy && o_mode_sw && !o_sw_oe && !i_sw_line &&
    r_reg.sw_low == 16'(dhs_pkg::SW_BREAK_CYC - 1)
    |=> r_reg.sw_st == dhs_pkg::SW_CMD && r_reg.sw_bits == 5'h00)
    else $error("break not recognised");
  a_startup_mode: assert property (
    !r_reg.ready && i_nv_valid |=> r_reg.ready && o_mode_sw == $past(i_nv_mode))
    else $error("stored protocol not loaded");

  c_break: cover property (r_reg.sw_st == dhs_pkg::SW_BRK ##1 r_reg.sw_st == dhs_pkg::SW_CMD);
  c_i2c_write: cover property (o_reg_wr && !o_mode_sw);
  c_switch: cover property (o_nv_wr);
  c_sleep: cover property ($rose(o_sleep));

endmodule // dhs_port

// *** dhs_pkg.sv ***
// Constants and timing counts shared by the dual host serial port
package dhs_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_NS = 20;

  // ==========================================================
  // Single-wire link timing, microseconds, then cycles
  localparam int START_LOW_TIME_US  = 10;
  localparam int DATA_SETUP_TIME_US = 30;
  localparam int DATA_VALID_TIME_US = 50;
  localparam int STOP_SETUP_TIME_US = 60;
  localparam int BIT_CYCLE_TIME_US  = 100;
  localparam int BREAK_TIME_US      = 80;
  localparam int TURN_TIME_US       = 20;

  // Least times round up, except the stop setup count, which truncates
  localparam int SW_START_CYC  = (START_LOW_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_SAMPLE_CYC = (DATA_SETUP_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_VALID_CYC  = (DATA_VALID_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_STOP_CYC   = (STOP_SETUP_TIME_US * 1000) / CLK_NS;
  localparam int SW_CYCLE_CYC  = (BIT_CYCLE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_BREAK_CYC  = (BREAK_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_TURN_CYC   = (TURN_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  // A reply waits for the host's last frame to end, then for the turnaround
  localparam int SW_TX_WAIT_CYC = SW_CYCLE_CYC - SW_SAMPLE_CYC + SW_TURN_CYC;

  // ==========================================================
  // I2C timeout and protocol switch delay
  localparam int BUS_LOW_TIME_MS   = 2;
  localparam int SWITCH_TIME_MS    = 200;
  localparam int BUS_LOW_CYC_DEF   = (BUS_LOW_TIME_MS * 1000000) / CLK_NS;
  localparam int SWITCH_CYC_DEF    = (SWITCH_TIME_MS * 1000000) / CLK_NS;

  // ==========================================================
  // Encodings
  localparam logic [6:0]  I2C_ADDR     = 7'h55;
  localparam int          CMD_HI_BIT   = 7;
  localparam int          SW_WRITE_BIT = 7;
  localparam logic [6:0]  CTL_LOC      = 7'h00;
  localparam logic [15:0] CODE_TO_SW   = 16'h7c40;
  localparam logic [15:0] CODE_TO_I2C  = 16'h29e7;
  localparam logic [1:0]  WR_MAX       = 2'h2;
  localparam logic        MODE_I2C_RST = 1'b0;

  typedef enum logic [2:0] {SW_BRK, SW_CMD, SW_DATA, SW_TURN, SW_TX} dhs_sw_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_CMD, I_WR, I_RD, I_MACK,
                            I_SKIP} dhs_i2c_e;

endpackage

// *** dhs_host_model.sv ***
// Host side model: I2C master and single-wire host on pulled-up lines
`timescale 1ns/10ps
module dhs_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_sda_oe,
  input  wire logic i_sw_oe,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_sw_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic sw_low  = 1'b0;
  // ==========================================================
  // Wired-and lines; a released line reads high through the pull-up
  assign o_scl     = ~scl_low;
  assign o_sda     = ~(sda_low | i_sda_oe);
  assign o_sw_line = ~(sw_low | i_sw_oe);
  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic hold_scl(input logic v);
    scl_low = v;
  endtask
  // ==========================================================
  // I2C, SCL high and low for four cycles each
  task automatic start();
    sda_low = 1'b0;
    wt(2);
    scl_low = 1'b0;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    wt(1);
    sda_low = 1'b1;
    wt(3);
    scl_low = 1'b0;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask
  task automatic bit_io(input logic b, output logic s);
    wt(1);
    sda_low = ~b;
    wt(3);
    scl_low = 1'b0;
    wt(2);
    s = o_sda;
    wt(2);
    scl_low = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask
  // ==========================================================
  // Single-wire: 100 us bit frames, a 1 releases at 10 us, a 0 at 60 us
  task automatic sw_bit(input logic b);
    sw_low = 1'b1;
    wt(b ? 500 : 3000);
    sw_low = 1'b0;
    wt(b ? 4500 : 2000);
  endtask
  task automatic sw_break();
    sw_low = 1'b1;
    wt(4100);
    sw_low = 1'b0;
    wt(1000);
  endtask
  task automatic sw_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) sw_bit(d[i]);
  endtask
endmodule // dhs_host_model

// *** dual_host_serial_port_test.sv ***
// Self-checking testbench of the dual host serial port
`timescale 1ns/10ps
module dual_host_serial_port_test;
  logic        clk;
  logic        rst = 1'b1;
  logic        scl, sda, sw_line, sda_oe, sw_oe;
  logic [6:0]  addr;
  logic [7:0]  wdata, d;
  logic        wr, rd, nv_wr, nv_mode, mode_sw, busy, sleep, a;
  logic [7:0]  regs [128];
  logic [14:0] expq [$];
  logic [31:0] seed = 32'h20;
  int          n_mismatch = 0;
  int          checks = 0;
  int          nv_seen = 0;
  int          n_rd = 0;
  logic        clk_en = 1'b1;
  logic        nv_valid = 1'b1;
  logic        nv_store = 1'b0;
  int          k;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  dhs_port #(.BUS_LOW_CYC(200), .SWITCH_CYC(50)) u_dut (
    .i_sys_clk(clk), .i_reset(rst), .i_clk_en(clk_en), .i_sw_line(sw_line),
    .o_sw_oe(sw_oe), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
    .i_reg_rdata(regs[addr]), .i_reg_ro(addr == 7'h20), .i_reg_wide(addr == 7'h06),
    .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .i_nv_valid(nv_valid), .i_nv_mode(nv_store), .o_nv_wr(nv_wr), .o_nv_mode(nv_mode),
    .o_mode_sw(mode_sw), .o_busy(busy), .o_sleep(sleep));
  dhs_host_model u_host (
    .i_sys_clk(clk), .i_sda_oe(sda_oe), .i_sw_oe(sw_oe),
    .o_scl(scl), .o_sda(sda), .o_sw_line(sw_line));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] v, input logic exp_ack);
    logic ack;
    u_host.wbyte(v, ack);
    check(16'(ack), 16'(exp_ack));
  endtask
  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Write monitor: each strobe takes the oldest expected write
  always @(negedge clk)
  begin
    if (wr === 1'b1)
    begin
      if (expq.size() == 0) check(16'h1, 16'h0);
      else check(16'({addr, wdata}), 16'(expq.pop_front()));
    end
    if (nv_wr === 1'b1)
    begin
      nv_seen++;
      nv_store = nv_mode;
      check(16'(nv_mode), 16'h1);
    end
    if (rd === 1'b1)
      n_rd++;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    for (int i = 0; i < 128; i++) regs[i] = rnd();
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(mode_sw), 16'h0);
    $display("test reset done");
    u_host.start();
    wb(8'haa, 1'b1);
    wb(8'h10, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      d = rnd();
      if (i < 2) expq.push_back({7'h10 + 7'(i), d});
      wb(d, i < 2);
    end
    u_host.stop();
    u_host.start();
    wb(8'ha8, 1'b0);
    u_host.stop();
    u_host.start();
    wb(8'haa, 1'b1);
    wb(8'h80, 1'b0);
    u_host.stop();
    u_host.start();
    wb(8'haa, 1'b1);
    wb(8'h20, 1'b1);
    wb(8'h5a, 1'b0);
    u_host.stop();
    $display("test i2c write done");
    u_host.start();
    wb(8'haa, 1'b1);
    wb(8'h30, 1'b1);
    u_host.stop();
    u_host.start();
    wb(8'hab, 1'b1);
    u_host.rbyte(1'b1, d);
    check(16'(d), 16'(regs[7'h30]));
    u_host.rbyte(1'b0, d);
    check(16'(d), 16'(regs[7'h31]));
    check(16'(n_rd), 16'h2);
    u_host.stop();
    $display("test i2c read done");
    // Stuck clock line: the device must let go, then sleep until freed
    u_host.hold_scl(1'b1);
    repeat (300) @(negedge clk);
    check(16'(sda_oe), 16'h0);
    check(16'(sleep), 16'h1);
    u_host.hold_scl(1'b0);
    repeat (4) @(negedge clk);
    check(16'(sleep), 16'h0);
    $display("test bus timeout done");
    u_host.start();
    wb(8'haa, 1'b1);
    wb(8'h00, 1'b1);
    expq.push_back({7'h00, 8'h40});
    wb(8'h40, 1'b1);
    expq.push_back({7'h01, 8'h7c});
    wb(8'h7c, 1'b0);
    check(16'(busy), 16'h1);
    // Clock enable low must freeze the switch countdown
    clk_en = 1'b0;
    repeat (80) @(negedge clk);
    check(16'(busy), 16'h1);
    clk_en = 1'b1;
    u_host.stop();
    for (k = 0; k < 200 && mode_sw !== 1'b1; k++) @(negedge clk);
    check(16'(mode_sw), 16'h1);
    check(16'(nv_seen), 16'h1);
    if (k >= 200) end_of_test();
    $display("test protocol switch done");
    d = rnd();
    u_host.sw_break();
    expq.push_back({7'h05, d});
    u_host.sw_byte(8'h85);
    u_host.sw_byte(d);
    repeat (20) @(negedge clk);
    check(16'(expq.size()), 16'h0);
    $display("test single-wire write done");
    // Mid-run reset: the protocol returns from the stored flag once it is valid
    rst = 1'b1;
    nv_valid = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(mode_sw), 16'h0);
    nv_valid = 1'b1;
    repeat (2) @(negedge clk);
    check(16'(mode_sw), 16'h1);
    $display("test restart done");
    end_of_test();
  end
endmodule // dual_host_serial_port_test
